//--- hw/prt_pkg.sv
package prt_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_CTRL = 10'h108;
  localparam logic [9:0] IDX_IOC  = 10'h10a;
  localparam logic [9:0] IDX_MODE = 10'h10b;
  localparam logic [9:0] IDX_PRE  = 10'h10c;
  localparam logic [9:0] IDX_TMR  = 10'h10d;

  // Mode register field positions
  localparam int MODE_LO = 0;
  localparam int WRC_BIT = 3;
  localparam int SRC_LO  = 4;
  localparam int CUT_BIT = 7;

  // Control register field positions
  localparam int START_BIT  = 0;
  localparam int STATUS_BIT = 1;
  localparam int STOP_BIT   = 2;

  // Reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [3:0] IOC_RST  = 4'h0;
  localparam logic [7:0] CNT_RST  = 8'h00;

  // Internal clock dividers for the slower count sources
  localparam int DIV_F2 = 2;
  localparam int DIV_F8 = 8;

  typedef enum logic [1:0] {
    PRT_TIMER   = 2'b00,
    PRT_WAVE    = 2'b01,
    PRT_ONESHOT = 2'b10,
    PRT_WAIT    = 2'b11
  } prt_mode_t;

  typedef enum logic [1:0] {
    PRT_F1   = 2'b00,
    PRT_F8   = 2'b01,
    PRT_COMP = 2'b10,
    PRT_F2   = 2'b11
  } prt_src_t;

endpackage

//--- hw/prt_stage_if.sv
`timescale 1ns/1ps
interface prt_stage_if #(parameter int W = 8);
  logic         tick;   // Count pulse into the stage
  logic         wr;     // Software write, always updates reload
  logic         now;    // Write also loads counter at once
  logic         sync;   // Write loads counter at next tick
  logic [W-1:0] wdata;  // Written value
  logic [W-1:0] count;  // Live counter
  logic         uflow;  // One-cycle underflow pulse

  modport ctl   (output tick, wr, now, sync, wdata, input count, uflow);
  modport stage (input tick, wr, now, sync, wdata, output count, uflow);
endinterface

//--- hw/prt_stage.sv
`timescale 1ns/1ps
module prt_stage #(
  parameter int W = 8
) (
  input wire logic    hclk,    // System clock
  input wire logic    hresetn, // Async reset, active low
  prt_stage_if.stage  sif      // Stage controls and status
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic [W-1:0] reload;
    logic         pend;
    logic         uflow;
  } prt_stage_st_t;

  prt_stage_st_t st;
  prt_stage_st_t next_st;

  // Down counter with reload; reload transfer waits for the count pulse
  always_comb begin
    next_st = st;
    next_st.uflow = 1'b0;
    if (sif.tick) begin
      if (st.pend) begin
        next_st.cnt  = st.reload;
        next_st.pend = 1'b0;
      end else if (st.cnt == '0) begin
        next_st.cnt   = st.reload;
        next_st.uflow = 1'b1;
      end else begin
        next_st.cnt = st.cnt - 1'b1;
      end
    end
    if (sif.wr) begin
      next_st.reload = sif.wdata;
      if (sif.now) begin
        next_st.cnt  = sif.wdata;
        next_st.pend = 1'b0;
      end else if (sif.sync) begin
        next_st.pend = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sif.count = st.cnt;
  assign sif.uflow = st.uflow;

  // Underflow reloads and pulses within one cycle
  reload_uflow_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (sif.tick && !st.pend && st.cnt == '0 && !sif.wr) |=> (st.uflow && st.cnt == $past(st.reload)))
    else $error("underflow did not reload");

  // A synchronous load waits for the next pulse
  sync_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (sif.wr && sif.sync && !sif.now && !sif.tick) |=> (st.pend && st.cnt == $past(st.cnt)))
    else $error("synchronous load was not deferred");

  // Reload-only write must leave the counter on its own decrement path
  reload_only_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (sif.wr && !sif.now && !sif.sync && !st.pend && st.cnt != '0)
      |=> (st.cnt == $past(st.cnt) - W'($past(sif.tick))))
    else $error("reload-only write changed counter");

endmodule

//--- hw/prt_src_sel.sv
`timescale 1ns/1ps
module prt_src_sel (
  input  wire logic             hclk,        // System clock
  input  wire logic             hresetn,     // Async reset, active low
  input  wire prt_pkg::prt_src_t sel,        // Count source choice
  input  wire logic             cut,         // Cut off the source
  input  wire logic             run,         // Counting enabled
  input  wire logic             comp_uflow,  // Companion timer underflow
  output logic                  tick         // Count pulse to prescaler
);

  typedef struct packed {
    logic [2:0] div;
  } prt_src_st_t;

  prt_src_st_t st;
  prt_src_st_t next_st;
  logic        f2_en;
  logic        f8_en;
  logic        raw;

  // Free-running divider gives f2 and f8 as one-cycle enables
  always_comb begin
    next_st.div = st.div + 3'h1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign f2_en = (st.div[0] == 1'b1);
  assign f8_en = (st.div == 3'(prt_pkg::DIV_F8 - 1));

  // Source mux; cutoff blocks the pulse entirely
  always_comb begin
    unique case (sel)
      prt_pkg::PRT_F1:   raw = 1'b1;
      prt_pkg::PRT_F8:   raw = f8_en;
      prt_pkg::PRT_COMP: raw = comp_uflow;
      prt_pkg::PRT_F2:   raw = f2_en;
    endcase
  end

  assign tick = raw && run && !cut;

endmodule

//--- hw/prt_timer.sv
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ps
// What this block does
// - Mode field 00 timer, 01 waveform, 10 one-shot, 11 wait one-shot.
// - Write control 0 writes reload and counter while counting, 1 reload only.
// - Source field picks f1, f8, companion underflow or f2.
// - Cutoff bit set blocks the count source completely.
// - Unassigned mode bits and upper I/O control bits read zero.
// - Counter decrements and reloads on underflow, then keeps counting.
// - Underflow period is source divided by (n+1)(m+1).
// - Writing start bit 1 begins counting.
// - Writing start 0 or forced-stop 1 stops counting.
// - Each timer-stage underflow raises the interrupt request.
// - Reading prescaler and timer returns live counter values.
// - Writes while stopped load reload and counter regardless of write control.
// - Timer mode: one-shot registers unused, output pin is plain port.
// - Reload-to-counter transfers wait for the stage's count pulse.
// - Status flag is read-only, 1 while counting, 0 when stopped.
// - Forced-stop stops at once and always reads back 0.
module prt_timer #(
  parameter int W = 8
) (
  input  wire logic        hclk,                    // Bus clock, 250 MHz
  input  wire logic        hresetn,                 // Async reset, active low
  input  wire logic        hsel,                    // Slave select
  input  wire logic [31:0] haddr,                   // Byte address
  input  wire logic [1:0]  htrans,                  // Transfer type
  input  wire logic        hwrite,                  // Write when high
  input  wire logic [2:0]  hsize,                   // Word only
  input  wire logic [31:0] hwdata,                  // Write data
  input  wire logic        hready,                  // Bus ready
  output logic             hreadyout,               // Always ready
  output logic             hresp,                   // Always OKAY
  output logic [31:0]      hrdata,                  // Read data
  input  wire logic        comp_uflow,              // Companion underflow pulse
  output logic             irq_underflow,           // Timer underflow request
  output logic             output_level_select,     // I/O control bit 0
  output logic             output_switch,           // I/O control bit 1
  output logic             trigger_pin_control,     // I/O control bit 2
  output logic             trigger_polarity_select, // I/O control bit 3
  output logic             out_pin_is_port          // Output pin acts as port
);

  typedef struct packed {
    logic             ap_valid;
    logic             ap_write;
    logic [9:0]       ap_idx;
    logic [31:0]      rdata;
    logic             start;
    logic             counting;
    prt_pkg::prt_mode_t mode;
    logic             wrc;
    prt_pkg::prt_src_t src;
    logic             cut;
    logic [3:0]       ioc;
  } prt_st_t;

  prt_st_t    st;
  prt_st_t    next_st;
  logic       wr_dp;
  logic [7:0] wd;
  logic       src_tick;
  logic       run;

  prt_stage_if #(.W(W)) pre_if ();
  prt_stage_if #(.W(W)) tmr_if ();

  // Register read mux, used at the address phase
  function automatic logic [31:0] rd_mux(input logic [9:0] idx, input prt_st_t s,
                                         input logic [W-1:0] pc, input logic [W-1:0] tc);
    logic [7:0] v;
    v = 8'h00;
    unique case (idx)
      prt_pkg::IDX_CTRL: v = {5'h00, 1'b0, s.counting, s.start};
      prt_pkg::IDX_IOC:  v = {4'h0, s.ioc};
      prt_pkg::IDX_MODE: v = {s.cut, 1'b0, s.src, s.wrc, 1'b0, s.mode};
      prt_pkg::IDX_PRE:  v = 8'(pc);
      prt_pkg::IDX_TMR:  v = 8'(tc);
      default:           v = 8'h00;
    endcase
    return {24'h00_0000, v};
  endfunction

  assign wr_dp = st.ap_valid && st.ap_write;
  assign wd    = hwdata[7:0];

  // Bus slave and control registers
  always_comb begin
    next_st = st;
    if (hready) begin
      next_st.ap_valid = hsel && htrans[1];
      next_st.ap_write = hwrite;
      next_st.ap_idx   = haddr[11:2];
      if (hsel && htrans[1] && !hwrite) begin
        next_st.rdata = rd_mux(haddr[11:2], st, pre_if.count, tmr_if.count);
      end
    end
    // Status flag trails the start bit by one cycle on start; a stop write clears both in the same cycle
    next_st.counting = st.start;
    if (wr_dp) begin
      unique case (st.ap_idx)
        prt_pkg::IDX_CTRL: begin
          next_st.start    = wd[prt_pkg::START_BIT];
          next_st.counting = st.counting && wd[prt_pkg::START_BIT];
          if (wd[prt_pkg::STOP_BIT]) begin
            next_st.start    = 1'b0;
            next_st.counting = 1'b0;
          end
        end
        prt_pkg::IDX_MODE: begin
          next_st.mode = prt_pkg::prt_mode_t'(wd[prt_pkg::MODE_LO +: 2]);
          next_st.wrc  = wd[prt_pkg::WRC_BIT];
          next_st.src  = prt_pkg::prt_src_t'(wd[prt_pkg::SRC_LO +: 2]);
          next_st.cut  = wd[prt_pkg::CUT_BIT];
        end
        prt_pkg::IDX_IOC: next_st.ioc = wd[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st       <= '0;
      st.mode  <= prt_pkg::prt_mode_t'(prt_pkg::MODE_RST[1:0]);
      st.src   <= prt_pkg::PRT_F1;
      st.ioc   <= prt_pkg::IOC_RST;
    end else begin
      st <= next_st;
    end
  end

  // Only timer mode counts; the other modes' pulse logic is not built
  assign run = st.counting && (st.mode == prt_pkg::PRT_TIMER);

  prt_src_sel u_src (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .sel        (st.src),
    .cut        (st.cut),
    .run        (run),
    .comp_uflow (comp_uflow),
    .tick       (src_tick)
  );

  // Stage writes: stopped loads both, running follows write control
  assign pre_if.tick  = src_tick;
  assign pre_if.wr    = wr_dp && (st.ap_idx == prt_pkg::IDX_PRE);
  assign pre_if.now   = !st.counting;
  assign pre_if.sync  = st.counting && !st.wrc;
  assign pre_if.wdata = W'(wd);
  assign tmr_if.tick  = pre_if.uflow;
  assign tmr_if.wr    = wr_dp && (st.ap_idx == prt_pkg::IDX_TMR);
  assign tmr_if.now   = !st.counting;
  assign tmr_if.sync  = st.counting && !st.wrc;
  assign tmr_if.wdata = W'(wd);

  prt_stage #(.W(W)) u_pre (
    .hclk    (hclk),
    .hresetn (hresetn),
    .sif     (pre_if)
  );

  prt_stage #(.W(W)) u_tmr (
    .hclk    (hclk),
    .hresetn (hresetn),
    .sif     (tmr_if)
  );

  assign irq_underflow           = tmr_if.uflow;
  assign hreadyout               = 1'b1;
  assign hresp                   = 1'b0;
  assign hrdata                  = st.rdata;
  assign output_level_select     = st.ioc[0];
  assign output_switch           = st.ioc[1];
  assign trigger_pin_control     = st.ioc[2];
  assign trigger_polarity_select = st.ioc[3];
  assign out_pin_is_port         = (st.mode == prt_pkg::PRT_TIMER);

  stop_clears_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_dp && st.ap_idx == prt_pkg::IDX_CTRL && wd[prt_pkg::STOP_BIT])
      |=> (!st.start && !st.counting))
    else $error("forced stop did not stop");

  start_sets_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_dp && st.ap_idx == prt_pkg::IDX_CTRL && wd[0] && !wd[prt_pkg::STOP_BIT])
      |=> st.start ##1 st.counting)
    else $error("start did not begin counting");

  mode_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (hready && hsel && htrans[1] && !hwrite && haddr[11:2] == prt_pkg::IDX_MODE)
      |=> (hrdata[2] == 1'b0 && hrdata[6] == 1'b0 && hrdata[31:8] == 24'h00_0000))
    else $error("reserved mode bits not zero");

  irq_cause_a: assert property (@(posedge hclk) disable iff (!hresetn)
    irq_underflow |-> ($past(pre_if.uflow) && $past(tmr_if.count) == '0))
    else $error("interrupt without underflow");

  // Watch the prescaler itself, not the gate that should freeze it
  cutoff_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st.cut && !pre_if.wr) |=> (pre_if.count == $past(pre_if.count)))
    else $error("count pulse passed cutoff");

  f1_source_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (run && !st.cut && st.src == prt_pkg::PRT_F1) |-> src_tick)
    else $error("f1 source not counting every cycle");

  stopped_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (pre_if.wr && !st.counting) |=> (pre_if.count == $past(pre_if.wdata)))
    else $error("stopped write did not load counter");

  mode_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st.mode != prt_pkg::PRT_TIMER && !pre_if.wr)
      |=> (pre_if.count == $past(pre_if.count)))
    else $error("counting outside timer mode");

  irq_seen_c: cover property (@(posedge hclk) disable iff (!hresetn) irq_underflow);
  stop_seen_c: cover property (@(posedge hclk) disable iff (!hresetn)
    st.counting ##1 !st.counting);
  sync_write_c: cover property (@(posedge hclk) disable iff (!hresetn)
    pre_if.wr && pre_if.sync);

endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, comp_uflow, comp_en;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        irq_underflow, out_pin_is_port;
  logic [3:0]  ioc_pins;
  logic [1:0]  comp_div;
  int          bad_count, checks, cycles, n;

  prt_timer #(.W(8)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .comp_uflow(comp_uflow),
    .irq_underflow(irq_underflow), .output_level_select(ioc_pins[0]),
    .output_switch(ioc_pins[1]), .trigger_pin_control(ioc_pins[2]),
    .trigger_polarity_select(ioc_pins[3]), .out_pin_is_port(out_pin_is_port));

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  // 250 MHz clock
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // Companion underflow every third cycle when enabled
  always @(posedge hclk) begin
    comp_div   <= (comp_div == 2'd2) ? 2'd0 : comp_div + 2'd1;
    comp_uflow <= comp_en && (comp_div == 2'd2);
  end

  // Hang guard, far beyond the expected run length
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One single AHB transfer; called just after a rising edge
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {20'h0_0000, idx, 2'b00};
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, wd};
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [31:0] dummy;
    bus(1'b1, idx, d, dummy);
  endtask

  // Idle cycle first so a preceding write is already visible
  task automatic rd(input logic [9:0] idx, output logic [31:0] v);
    @(posedge hclk);
    bus(1'b0, idx, 8'h00, v);
  endtask

  task automatic wait_irq(output int k);
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (irq_underflow !== 1'b1 && k < 3000);
  endtask

  task automatic t_reset_vals();
    logic [9:0] idx [5] = '{prt_pkg::IDX_CTRL, prt_pkg::IDX_IOC, prt_pkg::IDX_MODE,
                            prt_pkg::IDX_PRE, prt_pkg::IDX_TMR};
    foreach (idx[i]) begin
      rd(idx[i], rv);
      chk(rv, 32'h0000_0000);
    end
    rd(10'h100, rv);
    chk(rv, 32'h0000_0000);
    chk({31'h0, out_pin_is_port}, 32'h0000_0001);
    chk({31'h0, hresp}, 32'h0000_0000);
    chk({31'h0, hreadyout}, 32'h0000_0001);
  endtask

  task automatic t_fields();
    wr(prt_pkg::IDX_MODE, 8'hff);
    rd(prt_pkg::IDX_MODE, rv);
    chk(rv, 32'h0000_00bb);
    wr(prt_pkg::IDX_IOC, 8'hff);
    rd(prt_pkg::IDX_IOC, rv);
    chk(rv, 32'h0000_000f);
    chk({28'h0, ioc_pins}, 32'h0000_000f);
    // Every operating mode code, pin acts as port only in timer mode
    for (int m = 0; m < 4; m++) begin
      wr(prt_pkg::IDX_MODE, 8'(m));
      rd(prt_pkg::IDX_MODE, rv);
      chk(rv, 32'(m));
      chk({31'h0, out_pin_is_port}, {31'h0, m == 0});
    end
    wr(prt_pkg::IDX_IOC, 8'h00);
    rd(prt_pkg::IDX_IOC, rv);
    chk({28'h0, ioc_pins}, 32'h0000_0000);
  endtask

  // Stopped writes land in the counter even with reload-only selected
  task automatic t_stopped_write();
    wr(prt_pkg::IDX_MODE, 8'h08);
    wr(prt_pkg::IDX_PRE, 8'h05);
    rd(prt_pkg::IDX_PRE, rv);
    chk(rv, 32'h0000_0005);
    wr(prt_pkg::IDX_TMR, 8'h03);
    rd(prt_pkg::IDX_TMR, rv);
    chk(rv, 32'h0000_0003);
    wr(prt_pkg::IDX_MODE, 8'h00);
  endtask

  // Period for each source: n=2, m=3 gives 12 source pulses
  task automatic t_period();
    logic [7:0] srcs [4] = '{8'h00, 8'h10, 8'h20, 8'h30};
    int         mult [4] = '{1, 8, 3, 2};
    wr(prt_pkg::IDX_PRE, 8'h02);
    wr(prt_pkg::IDX_TMR, 8'h03);
    comp_en <= 1'b1;
    foreach (srcs[i]) begin
      wr(prt_pkg::IDX_CTRL, 8'h00);
      wr(prt_pkg::IDX_MODE, srcs[i]);
      wr(prt_pkg::IDX_CTRL, 8'h01);
      rd(prt_pkg::IDX_CTRL, rv);
      chk(rv, 32'h0000_0003);
      wait_irq(n);
      wait_irq(n);
      wait_irq(n);
      chk(32'(n), 32'(12 * mult[i]));
    end
    comp_en <= 1'b0;
    wr(prt_pkg::IDX_CTRL, 8'h00);
  endtask

  task automatic t_cutoff();
    logic [31:0] a;
    wr(prt_pkg::IDX_MODE, 8'h80);
    wr(prt_pkg::IDX_CTRL, 8'h01);
    rd(prt_pkg::IDX_PRE, a);
    wait_irq(n);
    rd(prt_pkg::IDX_PRE, rv);
    chk(rv, a);
    chk(32'(n), 32'd3000);
    wr(prt_pkg::IDX_CTRL, 8'h00);
    wr(prt_pkg::IDX_MODE, 8'h00);
  endtask

  task automatic t_stop();
    logic [31:0] a;
    wr(prt_pkg::IDX_CTRL, 8'h01);
    wr(prt_pkg::IDX_CTRL, 8'h05);
    rd(prt_pkg::IDX_CTRL, rv);
    chk(rv, 32'h0000_0000);
    rd(prt_pkg::IDX_TMR, a);
    repeat (20) @(posedge hclk);
    rd(prt_pkg::IDX_TMR, rv);
    chk(rv, a);
    wr(prt_pkg::IDX_CTRL, 8'h01);
    wr(prt_pkg::IDX_CTRL, 8'h00);
    rd(prt_pkg::IDX_CTRL, rv);
    chk(rv, 32'h0000_0000);
  endtask

  // Rewrite during count, reload-only then reload-and-counter
  task automatic t_live_write();
    logic [31:0] a;
    wr(prt_pkg::IDX_PRE, 8'h00);
    wr(prt_pkg::IDX_TMR, 8'h40);
    wr(prt_pkg::IDX_MODE, 8'h08);
    wr(prt_pkg::IDX_CTRL, 8'h01);
    rd(prt_pkg::IDX_TMR, a);
    wr(prt_pkg::IDX_TMR, 8'h10);
    rd(prt_pkg::IDX_TMR, rv);
    chk({31'h0, rv < a}, 32'h0000_0001);
    chk({31'h0, rv > 32'h10}, 32'h0000_0001);
    wr(prt_pkg::IDX_CTRL, 8'h00);
    wr(prt_pkg::IDX_MODE, 8'h00);
    wr(prt_pkg::IDX_TMR, 8'h40);
    wr(prt_pkg::IDX_CTRL, 8'h01);
    wr(prt_pkg::IDX_TMR, 8'h05);
    wr(prt_pkg::IDX_PRE, 8'h00);
    rd(prt_pkg::IDX_TMR, rv);
    chk({31'h0, rv <= 32'h5}, 32'h0000_0001);
    wr(prt_pkg::IDX_CTRL, 8'h00);
  endtask

  task automatic report_and_stop();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Reset for four cycles, then the scenarios in order
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    comp_en = 1'b0;
    comp_div = 2'd0;
    comp_uflow = 1'b0;
    bad_count = 0;
    checks = 0;
    cycles = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset_vals();
    t_fields();
    t_stopped_write();
    t_period();
    t_cutoff();
    t_stop();
    t_live_write();
    report_and_stop();
  end
endmodule
